// file: fcd_pkg.sv
package fcd_pkg;
   localparam logic [10:0] UNLOCK_A1_WORD = 11'h555;
   localparam logic [10:0] UNLOCK_A2_WORD = 11'h2AA;
   localparam logic [11:0] UNLOCK_A1_BYTE = 12'hAAA;
   localparam logic [11:0] UNLOCK_A2_BYTE = 12'h555;
   localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
   localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_BYPASS = 8'h20;
   localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
   localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0] CMD_SUSPEND = 8'hB0;
   localparam logic [7:0] CMD_RESUME = 8'h30;
   localparam logic [7:0] CMD_IDENT = 8'h90;
   localparam logic [7:0] CMD_BYPASS_EXIT1 = 8'h90;
   localparam logic [7:0] CMD_BYPASS_EXIT2 = 8'h00;
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [10:0] ID_DEV_WORD = 11'h001;
   localparam logic [11:0] ID_DEV_BYTE = 12'h002;
   localparam logic [10:0] PROT_WORD = 11'h002;
   localparam logic [11:0] PROT_BYTE = 12'h004;
   localparam int ADDR_W = 18;
   localparam int SECT_LSB = 12;
   // strobe phases: setup, low, hold in cycles (40 ns each)
   localparam int T_SETUP_NS = 40;
   localparam int T_WP_NS = 80;
   localparam int T_HOLD_NS = 40;
   localparam int CLK_NS = 40;
   localparam logic [3:0] SETUP_CYC = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] WP_CYC = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] HOLD_CYC = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RD_CYC = 4'd3;

   typedef enum logic [3:0] {
      FCD_OP_READ = 4'h0,
      FCD_OP_PROGRAM = 4'h1,
      FCD_OP_BYPASS_ENTER = 4'h2,
      FCD_OP_BYPASS_PROGRAM = 4'h3,
      FCD_OP_BYPASS_EXIT = 4'h4,
      FCD_OP_CHIP_ERASE = 4'h5,
      FCD_OP_SECTOR_ERASE = 4'h6,
      FCD_OP_SECTOR_MORE = 4'h7,
      FCD_OP_SUSPEND = 4'h8,
      FCD_OP_RESUME = 4'h9,
      FCD_OP_IDENT = 4'hA,
      FCD_OP_PROT_VERIFY = 4'hB,
      FCD_OP_RESET = 4'hC
   } fcd_op_t;

   typedef struct packed {
      fcd_op_t op;
      logic [17:0] addr;
      logic [15:0] data;
   } fcd_req_t;

   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [17:0] addr;
      logic byte_lo;
   } fcd_bus_t;
endpackage

// file: fcd_cycle.sv
`timescale 1ns/1ps
// one bus cycle on the flash pins: write or read
module fcd_cycle
   import fcd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic is_read,
   input wire logic byte_mode,
   input wire logic [11:0] low_addr,
   input wire logic [17:0] full_addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] dq_in,
   output fcd_pkg::fcd_bus_t bus,
   output logic [15:0] dq_out,
   output logic dq_oe,
   output logic [15:0] rdata,
   output logic done
);
   typedef enum logic [1:0] {
      FCD_C_IDLE = 2'b00,
      FCD_C_SETUP = 2'b01,
      FCD_C_STROBE = 2'b10,
      FCD_C_HOLD = 2'b11
   } fcd_cst_t;
   fcd_cst_t st_ff;
   logic [3:0] cnt_ff;
   logic rd_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= FCD_C_IDLE;
         cnt_ff <= 4'h0;
         rd_ff <= 1'b0;
         done <= 1'b0;
         bus <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 18'h0, byte_lo: 1'b0};
         dq_out <= 16'h0;
         dq_oe <= 1'b0;
         rdata <= 16'h0;
      end
      else
      begin
         done <= 1'b0;
         case (st_ff)
            FCD_C_IDLE:
               if (start)
               begin
                  rd_ff <= is_read;
                  // word mode uses A[10:0]; byte mode adds the lane bit
                  bus.addr <= {full_addr[17:11],
                     byte_mode ? low_addr[11:1] : low_addr[10:0]};
                  bus.byte_lo <= byte_mode & low_addr[0];
                  bus.ce_n <= 1'b0;
                  dq_out <= wdata;
                  dq_oe <= !is_read;
                  cnt_ff <= SETUP_CYC;
                  st_ff <= FCD_C_SETUP;
               end
            FCD_C_SETUP:
               if (cnt_ff <= 4'h1)
               begin
                  if (rd_ff)
                     bus.oe_n <= 1'b0;
                  else
                     bus.we_n <= 1'b0;
                  cnt_ff <= rd_ff ? RD_CYC : WP_CYC;
                  st_ff <= FCD_C_STROBE;
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            FCD_C_STROBE:
               if (cnt_ff <= 4'h1)
               begin
                  // data latched by the device at this rising edge
                  bus.we_n <= 1'b1;
                  bus.oe_n <= 1'b1;
                  if (rd_ff)
                     rdata <= dq_in;
                  cnt_ff <= HOLD_CYC;
                  st_ff <= FCD_C_HOLD;
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            FCD_C_HOLD:
               if (cnt_ff <= 4'h1)
               begin
                  bus.ce_n <= 1'b1;
                  dq_oe <= 1'b0;
                  done <= 1'b1;
                  st_ff <= FCD_C_IDLE;
               end
               else
                  cnt_ff <= cnt_ff - 4'h1;
            default:
               st_ff <= FCD_C_IDLE;
         endcase
      end
   end
endmodule

// file: fcd_host.sv
`timescale 1ns/1ps
// Contract
// R1: program is two unlocks, setup A0, then address and data.
// R2: upper data byte is don't care on unlock and command cycles.
// R3: command addresses use A[10:0], plus lane bit in byte mode.
// R4: sector from A[17:12] on erase sixth or verify fourth cycle.
// R5: single F0 write returns to read; needed after ident or timeout.
// R6: reset aborts erase sequence before erasure; ignored afterwards.
// R7: reset between program cycles aborts to read or suspend.
// R8: all commands ignored while program algorithm runs.
// R9: suspend B0 accepted only during sector erase; host issues it whenever RY_BY_N is low and IN_SUSPEND is clear, chip erase included.
// R10: suspended device allows reads, programs elsewhere, identification.
// R11: resume 30 accepted only while erase-suspended.
// R12: bypass program only after bypass entry sequence.
// R13: fourth cycle of ident or verify is a read.
// R14: reset aborts ident sequence; ident mode held until reset.
// R15: after timeout flag set, reset needed to return to read.
// R16: verify read at offset 02/04 returns 01 protected, 00 not.
// R17: after last program cycle the device runs its own algorithm.
// R18: hardware reset ends a program; host reissues it.
// R19: programming only clears bits; stored zeros stay zero.
// R20: ident device code read at X01 word or X02 byte.
// R21: wrong address, data or order returns device to read.
// R22: address latched at later fall, data at earlier rise.
// R23: 20 after two unlocks enters bypass; A0 then data programs.
// R24: unlock addresses chosen by current bus width.
module fcd_host
   import fcd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   input fcd_pkg::fcd_req_t REQ,
   input wire logic BYTE_MODE,
   input wire logic [15:0] DQ_IN,
   input wire logic RY_BY_N,
   output logic REQ_READY,
   output logic DONE,
   output logic [15:0] RDATA,
   output logic REFUSED,
   output logic TIMEOUT_SEEN,
   output logic IN_BYPASS,
   output logic IN_SUSPEND,
   output logic IN_IDENT,
   output fcd_pkg::fcd_bus_t FLASH_BUS,
   output logic [15:0] DQ_OUT,
   output logic DQ_OE,
   output logic FLASH_RESET_N
);
   import fcd_pkg::*;

   typedef enum logic [2:0] {
      FCD_S_IDLE = 3'b000,
      FCD_S_ISSUE = 3'b001,
      FCD_S_WAIT = 3'b010,
      FCD_S_POLL = 3'b011,
      FCD_S_FINISH = 3'b100
   } fcd_state_t;

   fcd_state_t state_ff;
   fcd_req_t req_ff;
   logic [2:0] idx_ff;
   logic [2:0] n_cyc;
   logic cyc_start_ff;
   logic cyc_read;
   logic [11:0] cyc_low;
   logic [17:0] cyc_full;
   logic [15:0] cyc_data;
   logic cyc_done;
   logic [15:0] cyc_rdata;
   logic [15:0] dq_out_w;
   logic dq_oe_w;
   fcd_bus_t bus_w;
   logic [11:0] a1;
   logic [11:0] a2;
   logic legal;
   logic busy_alg;

   // R24 width-dependent unlock addresses
   assign a1 = BYTE_MODE ? UNLOCK_A1_BYTE : {1'b0, UNLOCK_A1_WORD};
   assign a2 = BYTE_MODE ? UNLOCK_A2_BYTE : {1'b0, UNLOCK_A2_WORD};

   // R12 bypass program only in bypass; R9 R11 suspend/resume gating
   always_comb
   begin
      legal = 1'b1;
      case (req_ff.op)
         FCD_OP_BYPASS_PROGRAM,
         FCD_OP_BYPASS_EXIT: legal = IN_BYPASS;
         FCD_OP_SUSPEND: legal = busy_alg && !IN_SUSPEND;
         FCD_OP_RESUME: legal = IN_SUSPEND;
         FCD_OP_SECTOR_MORE: legal = busy_alg;
         FCD_OP_RESET: legal = !busy_alg || TIMEOUT_SEEN;
         default: legal = !IN_BYPASS && !busy_alg && !IN_IDENT;
      endcase
      // R10 program and identification allowed while suspended
      if (IN_SUSPEND && (req_ff.op == FCD_OP_PROGRAM || req_ff.op == FCD_OP_IDENT
         || req_ff.op == FCD_OP_READ))
         legal = 1'b1;
   end

   // cycle count per sequence; R1 R13 R23
   always_comb
   begin
      case (req_ff.op)
         FCD_OP_PROGRAM: n_cyc = 3'd4;
         FCD_OP_BYPASS_ENTER: n_cyc = 3'd3;
         FCD_OP_BYPASS_PROGRAM: n_cyc = 3'd2;
         FCD_OP_BYPASS_EXIT: n_cyc = 3'd2;
         FCD_OP_CHIP_ERASE: n_cyc = 3'd6;
         FCD_OP_SECTOR_ERASE: n_cyc = 3'd6;
         FCD_OP_IDENT: n_cyc = 3'd4;
         FCD_OP_PROT_VERIFY: n_cyc = 3'd4;
         default: n_cyc = 3'd1;
      endcase
   end

   // per-cycle address and data; R2 upper byte zero on commands
   always_comb
   begin
      cyc_read = 1'b0;
      cyc_full = 18'h0;
      cyc_low = 12'h0;
      cyc_data = 16'h0;
      case (idx_ff)
         3'd0, 3'd3:
         begin
            cyc_low = a1;
            cyc_data = {8'h00, DATA_UNLOCK1};
         end
         3'd1, 3'd4:
         begin
            cyc_low = a2;
            cyc_data = {8'h00, DATA_UNLOCK2};
         end
         default:
         begin
            cyc_low = a1;
            cyc_data = 16'h0;
         end
      endcase
      if (idx_ff == 3'd2)
         case (req_ff.op)
            FCD_OP_PROGRAM: cyc_data = {8'h00, CMD_PROGRAM};
            FCD_OP_BYPASS_ENTER: cyc_data = {8'h00, CMD_BYPASS};
            FCD_OP_IDENT, FCD_OP_PROT_VERIFY: cyc_data = {8'h00, CMD_IDENT};
            default: cyc_data = {8'h00, CMD_ERASE_SETUP};
         endcase
      if (idx_ff == 3'd5 && req_ff.op == FCD_OP_CHIP_ERASE)
         cyc_data = {8'h00, CMD_CHIP_ERASE};
      // R4 sector select on sixth erase cycle
      if (idx_ff == 3'd5 && req_ff.op == FCD_OP_SECTOR_ERASE)
      begin
         cyc_full = req_ff.addr;
         cyc_low = req_ff.addr[11:0];
         cyc_data = {8'h00, CMD_SECTOR_ERASE};
      end
      case (req_ff.op)
         FCD_OP_PROGRAM, FCD_OP_BYPASS_PROGRAM:
            if (idx_ff == n_cyc - 3'd1)
            begin
               // R17 last cycle carries target address and value
               cyc_full = req_ff.addr;
               cyc_low = req_ff.addr[11:0];
               cyc_data = req_ff.data;
            end
            else if (req_ff.op == FCD_OP_BYPASS_PROGRAM)
               cyc_data = {8'h00, CMD_PROGRAM};
         FCD_OP_BYPASS_EXIT:
            cyc_data = {8'h00, (idx_ff == 3'd0) ? CMD_BYPASS_EXIT1 : CMD_BYPASS_EXIT2};
         FCD_OP_IDENT, FCD_OP_PROT_VERIFY:
            if (idx_ff == 3'd3)
            begin
               // R13 fourth cycle is a read; R16 R20 offsets
               cyc_read = 1'b1;
               cyc_full = {req_ff.addr[17:SECT_LSB], 12'h000};
               if (req_ff.op == FCD_OP_PROT_VERIFY)
                  cyc_low = BYTE_MODE ? PROT_BYTE : {1'b0, PROT_WORD};
               else
                  cyc_low = BYTE_MODE ? ID_DEV_BYTE : {1'b0, ID_DEV_WORD};
            end
         FCD_OP_SUSPEND: cyc_data = {8'h00, CMD_SUSPEND};
         FCD_OP_RESUME: cyc_data = {8'h00, CMD_RESUME};
         FCD_OP_SECTOR_MORE:
         begin
            cyc_full = req_ff.addr;
            cyc_low = req_ff.addr[11:0];
            cyc_data = {8'h00, CMD_SECTOR_ERASE};
         end
         FCD_OP_RESET: cyc_data = {8'h00, CMD_RESET};
         FCD_OP_READ:
         begin
            cyc_read = 1'b1;
            cyc_full = req_ff.addr;
            cyc_low = req_ff.addr[11:0];
         end
         default: ;
      endcase
   end

   fcd_cycle u_cycle (
      .clk(SYS_CLK),
      .rst_n(RST_N),
      .start(cyc_start_ff),
      .is_read(cyc_read),
      .byte_mode(BYTE_MODE),
      .low_addr(cyc_low),
      .full_addr(cyc_full),
      .wdata(cyc_data),
      .dq_in(DQ_IN),
      .bus(bus_w),
      .dq_out(dq_out_w),
      .dq_oe(dq_oe_w),
      .rdata(cyc_rdata),
      .done(cyc_done)
   );

   // R22 pin timing is ce first, we later; data held past we rise
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         FLASH_BUS <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 18'h0, byte_lo: 1'b0};
         DQ_OUT <= 16'h0;
         DQ_OE <= 1'b0;
         FLASH_RESET_N <= 1'b0;
      end
      else
      begin
         FLASH_BUS <= bus_w;
         DQ_OUT <= dq_out_w;
         DQ_OE <= dq_oe_w;
         // R18 flash held in reset with the host
         FLASH_RESET_N <= 1'b1;
      end
   end

   // sequencer
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         state_ff <= FCD_S_IDLE;
         req_ff <= '0;
         idx_ff <= 3'd0;
         cyc_start_ff <= 1'b0;
         REQ_READY <= 1'b1;
         DONE <= 1'b0;
         REFUSED <= 1'b0;
         RDATA <= 16'h0;
      end
      else
      begin
         DONE <= 1'b0;
         REFUSED <= 1'b0;
         cyc_start_ff <= 1'b0;
         case (state_ff)
            FCD_S_IDLE:
               if (REQ_VALID && REQ_READY)
               begin
                  req_ff <= REQ;
                  idx_ff <= 3'd0;
                  REQ_READY <= 1'b0;
                  state_ff <= FCD_S_ISSUE;
               end
            FCD_S_ISSUE:
               if (!legal)
               begin
                  REFUSED <= 1'b1;
                  state_ff <= FCD_S_FINISH;
               end
               else
               begin
                  cyc_start_ff <= 1'b1;
                  state_ff <= FCD_S_WAIT;
               end
            FCD_S_WAIT:
               if (cyc_done)
               begin
                  if (cyc_read)
                     RDATA <= cyc_rdata;
                  if (idx_ff == n_cyc - 3'd1)
                     state_ff <= FCD_S_POLL;
                  else
                  begin
                     idx_ff <= idx_ff + 3'd1;
                     cyc_start_ff <= 1'b1;
                  end
               end
            FCD_S_POLL:
               // R8 R17 wait out the program algorithm
               if (!((req_ff.op == FCD_OP_PROGRAM || req_ff.op == FCD_OP_BYPASS_PROGRAM)
                  && !RY_BY_N))
                  state_ff <= FCD_S_FINISH;
            FCD_S_FINISH:
            begin
               DONE <= 1'b1;
               REQ_READY <= 1'b1;
               state_ff <= FCD_S_IDLE;
            end
            default:
               state_ff <= FCD_S_IDLE;
         endcase
      end
   end

   // mode tracking
   always_ff @(posedge SYS_CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         IN_BYPASS <= 1'b0;
         IN_SUSPEND <= 1'b0;
         IN_IDENT <= 1'b0;
         TIMEOUT_SEEN <= 1'b0;
      end
      else
      begin
         if (state_ff == FCD_S_POLL)
            case (req_ff.op)
               FCD_OP_BYPASS_ENTER: IN_BYPASS <= 1'b1;
               FCD_OP_BYPASS_EXIT: IN_BYPASS <= 1'b0;
               FCD_OP_SUSPEND: IN_SUSPEND <= 1'b1;
               FCD_OP_RESUME: IN_SUSPEND <= 1'b0;
               // R14 identification mode held until reset
               FCD_OP_IDENT, FCD_OP_PROT_VERIFY: IN_IDENT <= 1'b1;
               // R5 R15 reset leaves ident and clears timeout
               FCD_OP_RESET:
               begin
                  IN_IDENT <= 1'b0;
                  TIMEOUT_SEEN <= 1'b0;
               end
               default: ;
            endcase
         // R15 timeout flag on DQ[5] while busy; set wins
         if (!RY_BY_N && DQ_IN[5])
            TIMEOUT_SEEN <= 1'b1;
      end
   end

   assign busy_alg = !RY_BY_N;
endmodule

// file: fcd_host_chk.sv
`timescale 1ns/1ps
module fcd_host_chk
   import fcd_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic REQ_VALID,
   input fcd_pkg::fcd_req_t REQ,
   input wire logic [15:0] DQ_IN,
   input wire logic RY_BY_N,
   input wire logic REQ_READY,
   input wire logic REFUSED,
   input wire logic TIMEOUT_SEEN,
   input wire logic IN_BYPASS,
   input wire logic IN_SUSPEND,
   input fcd_pkg::fcd_bus_t FLASH_BUS,
   input wire logic [15:0] DQ_OUT,
   input wire logic FLASH_RESET_N
);
   wire logic take = REQ_VALID && REQ_READY;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   sequence s_wlow;
      !FLASH_BUS.we_n && !FLASH_BUS.ce_n && $stable(FLASH_BUS.addr) && $stable(DQ_OUT);
   endsequence
   sequence s_hold;
      (FLASH_BUS.we_n && !FLASH_BUS.ce_n) ##1 FLASH_BUS.ce_n;
   endsequence
   property p_wr;
      $fell(FLASH_BUS.we_n) |-> s_wlow [*2] ##1 s_hold;
   endproperty
   a_wr: assert property (p_wr) else $error("write strobe shape wrong");
   property p_setup;
      $fell(FLASH_BUS.we_n) |-> !$past(FLASH_BUS.ce_n);
   endproperty
   a_setup: assert property (p_setup) else $error("no chip enable setup");
   property p_rd;
      $fell(FLASH_BUS.oe_n) |-> (!FLASH_BUS.oe_n && FLASH_BUS.we_n) [*3] ##1 FLASH_BUS.oe_n;
   endproperty
   a_rd: assert property (p_rd) else $error("read strobe shape wrong");
   property p_rst;
      !FLASH_RESET_N |=> FLASH_RESET_N;
   endproperty
   a_rst: assert property (p_rst) else $error("flash reset held");
   property p_take;
      take |=> !REQ_READY;
   endproperty
   a_take: assert property (p_take) else $error("ready after take");
   property p_byp;
      take && REQ.op == FCD_OP_BYPASS_PROGRAM && !IN_BYPASS |-> ##[2:3] REFUSED;
   endproperty
   a_byp: assert property (p_byp) else $error("bypass program not refused");
   property p_res;
      take && REQ.op == FCD_OP_RESUME && !IN_SUSPEND |-> ##[2:3] REFUSED;
   endproperty
   a_res: assert property (p_res) else $error("resume not refused");
   property p_tmo;
      !RY_BY_N && DQ_IN[5] |-> ##[1:3] TIMEOUT_SEEN;
   endproperty
   a_tmo: assert property (p_tmo) else $error("timeout flag missed");
endmodule

bind fcd_host fcd_host_chk i_fcd_host_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
   .REQ_VALID(REQ_VALID), .REQ(REQ), .DQ_IN(DQ_IN), .RY_BY_N(RY_BY_N), .REQ_READY(REQ_READY),
   .REFUSED(REFUSED), .TIMEOUT_SEEN(TIMEOUT_SEEN), .IN_BYPASS(IN_BYPASS),
   .IN_SUSPEND(IN_SUSPEND), .FLASH_BUS(FLASH_BUS), .DQ_OUT(DQ_OUT),
   .FLASH_RESET_N(FLASH_RESET_N));

// file: fcd_flash_model.sv
`timescale 1ns/1ps
module fcd_flash_model
   import fcd_pkg::*;
#(
   // arbitrary value
   parameter logic [15:0] DEV_ID = 16'h5A3C,
   parameter logic [63:0] PROT = 64'h4,
   parameter int BUSY_CYC = 40
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic byte_mode,
   input fcd_pkg::fcd_bus_t bus,
   input wire logic [15:0] dq_out,
   output logic [15:0] dq_in,
   output logic ry_by_n
);
   logic [15:0] mem [int];
   logic [17:0] la, pa;
   logic [15:0] pm, rv, last = 16'h0;
   logic [11:0] off, ro;
   bit byp, sus, idn, dq5, wact, c1, c2, chip;
   int st, pb, eb;
   wire logic drv = !bus.ce_n && !bus.oe_n;
   function automatic logic [15:0] rd(int a);
      return mem.exists(a) ? mem[a] : 16'hFFFF;
   endfunction
   task automatic wr(logic [7:0] d);
      off = byte_mode ? {la[10:0], bus.byte_lo} : {1'b0, la[10:0]};
      c1 = off == (byte_mode ? 12'hAAA : 12'h555);
      c2 = off == (byte_mode ? 12'h555 : 12'h2AA);
      if (pb > 0 || (eb > 0 && !sus))
      begin
         if (pb == 0 && d == 8'hB0 && !chip) sus = 1;
         return;
      end
      if (sus && st == 0 && d == 8'h30) sus = 0;
      else if (d == 8'hF0) {st, idn, dq5} = '0;
      else if (!idn)
         case (st)
            0: st = byp ? (d == 8'hA0 ? 3 : d == 8'h90 ? 7 : 0) : int'(c1 && d == 8'hAA);
            1, 5: st = c2 && d == 8'h55 ? st + 1 : 0;
            2:
            begin
               idn = c1 && d == 8'h90;
               byp = c1 && d == 8'h20 && !sus;
               st = !c1 ? 0 : d == 8'hA0 ? 3 : d == 8'h80 && !sus ? 4 : 0;
            end
            4: st = c1 && d == 8'hAA ? 5 : 0;
            6:
            begin
               chip = d == 8'h10;
               eb = (chip || d == 8'h30) ? 4 * BUSY_CYC : 0;
               st = 0;
            end
            7:
            begin
               byp = d != 8'h00;
               st = 0;
            end
            3:
            begin
               dq5 = (~rd(la) & dq_out) != 16'h0;
               pa = la;
               pm = rd(la) & dq_out;
               pb = BUSY_CYC;
               st = 0;
            end
            default: st = 0;
         endcase
   endtask
   always @(negedge bus.we_n or negedge bus.ce_n)
      if (!bus.we_n && !bus.ce_n && bus.oe_n)
      begin
         la = bus.addr;
         wact = 1;
      end
   always @(posedge bus.we_n or posedge bus.ce_n)
      if (wact && rst_n)
      begin
         wact = 0;
         wr(dq_out[7:0]);
      end
   always @(posedge clk or negedge rst_n)
      if (!rst_n)
      begin
         {st, pb, eb} = '0;
         {byp, sus, idn, dq5, wact} = '0;
      end
      else
      begin
         if (pb == 1 && !dq5) mem[pa] = pm;
         if (eb == 1 && chip && !sus) mem.delete();
         if (pb > 0) pb--;
         if (eb > 0 && !sus) eb--;
         if (drv) last = rv;
      end
   always @*
   begin
      ro = byte_mode ? {bus.addr[10:0], bus.byte_lo} : {1'b0, bus.addr[10:0]};
      if (!ry_by_n || dq5) rv = {10'h0, dq5, 5'h0};
      else if (idn && ro == (byte_mode ? 12'h002 : 12'h001)) rv = DEV_ID;
      else if (idn) rv = {15'h0, PROT[bus.addr[17:12]]};
      else rv = rd(bus.addr);
   end
   assign ry_by_n = !(pb > 0 || (eb > 0 && !sus));
   // released bus shows inverse of last value except DQ[5], which carries dq5
   assign dq_in = drv ? rv : {~last[15:6], dq5, ~last[4:0]};
endmodule

// file: testbench.sv
`timescale 1ns/1ps
module testbench;
   import fcd_pkg::*;
   localparam logic [15:0] DEV_ID = 16'h5A3C; // arbitrary value
   logic clk = 0;
   logic rst_n = 0;
   logic req_valid = 0;
   logic byte_mode = 0;
   fcd_req_t req = '0;
   logic [15:0] dq_in, dq_out, rdata, seed = 16'd38049;
   logic ry_n, ready, done, refused, tmo, in_byp, in_sus, in_idn, dq_oe, fl_rst_n;
   fcd_bus_t fbus;
   int miscompares = 0;
   int samples_checked = 0;
   logic [15:0] em [int];
   always #20 clk = ~clk;
   fcd_host i_fcd_host (.SYS_CLK(clk), .RST_N(rst_n), .REQ_VALID(req_valid), .REQ(req),
      .BYTE_MODE(byte_mode), .DQ_IN(dq_in), .RY_BY_N(ry_n), .REQ_READY(ready), .DONE(done),
      .RDATA(rdata), .REFUSED(refused), .TIMEOUT_SEEN(tmo), .IN_BYPASS(in_byp),
      .IN_SUSPEND(in_sus), .IN_IDENT(in_idn), .FLASH_BUS(fbus), .DQ_OUT(dq_out),
      .DQ_OE(dq_oe), .FLASH_RESET_N(fl_rst_n));
   fcd_flash_model #(.DEV_ID(DEV_ID), .PROT(64'h4), .BUSY_CYC(40)) i_fcd_flash_model (
      .clk(clk), .rst_n(fl_rst_n), .byte_mode(byte_mode), .bus(fbus), .dq_out(dq_out),
      .dq_in(dq_in), .ry_by_n(ry_n));
   function automatic logic [15:0] nxt(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] rd(int a);
      return em.exists(a) ? em[a] : 16'hFFFF;
   endfunction
   task automatic chk(logic [15:0] seen, logic [15:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic op(fcd_op_t o, logic [17:0] a, logic [15:0] d, logic e, int cut = 0);
      logic rf;
      int n;
      rf = 0;
      n = 0;
      @(negedge clk);
      while (ready !== 1) @(negedge clk);
      req_valid = 1;
      req = '{o, a, d};
      @(negedge clk);
      req_valid = 0;
      while (done !== 1 && n < 3000)
      begin
         rf |= refused;
         if (cut > 0 && n == cut)
         begin
            rst_n = 0;
            repeat (2) @(negedge clk);
            rst_n = 1;
            return;
         end
         @(negedge clk);
         n++;
      end
      chk({rf, done}, {e, 1'b1});
   endtask
   task automatic rdchk(logic [17:0] a);
      op(FCD_OP_READ, a, 0, 0);
      chk(rdata, rd(a));
   endtask
   task automatic wait_ry;
      int n = 0;
      while (ry_n !== 1 && n < 3000)
      begin
         @(negedge clk);
         n++;
      end
      chk(ry_n, 1);
   endtask
   initial
   begin
      #(40 * 30000);
      miscompares++;
      close_out;
   end
   initial
   begin
      logic [17:0] a;
      repeat (2) @(negedge clk);
      rst_n = 1;
      @(negedge clk);
      chk(fl_rst_n, 1);
      repeat (4)
      begin
         seed = nxt(seed);
         a = {2'b00, seed};
         seed = nxt(seed);
         op(FCD_OP_PROGRAM, a, seed, 0);
         em[a] = rd(a) & seed;
         rdchk(a);
      end
      op(FCD_OP_PROGRAM, a, 16'hFFFF, 0);
      chk(tmo, rd(a) != 16'hFFFF);
      op(FCD_OP_RESET, 0, 0, 0);
      chk(tmo, 0);
      rdchk(a);
      op(FCD_OP_BYPASS_PROGRAM, a, 0, 1);
      op(FCD_OP_BYPASS_ENTER, 0, 0, 0);
      chk(in_byp, 1);
      a = a ^ 18'h00100;
      op(FCD_OP_BYPASS_PROGRAM, a, 16'h1234, 0);
      em[a] = rd(a) & 16'h1234;
      op(FCD_OP_BYPASS_EXIT, 0, 0, 0);
      chk(in_byp, 0);
      rdchk(a);
      op(FCD_OP_IDENT, 18'h00001, 0, 0);
      chk(rdata, DEV_ID);
      chk(in_idn, 1);
      op(FCD_OP_RESET, 0, 0, 0);
      chk(in_idn, 0);
      for (int s = 1; s < 3; s++)
      begin
         op(FCD_OP_PROT_VERIFY, {s[5:0], 12'h002}, 0, 0);
         chk(rdata, s == 2);
         op(FCD_OP_RESET, 0, 0, 0);
      end
      op(FCD_OP_SUSPEND, 0, 0, 1);
      op(FCD_OP_RESUME, 0, 0, 1);
      op(FCD_OP_SECTOR_ERASE, 18'h05000, 0, 0);
      op(FCD_OP_SUSPEND, 0, 0, 0);
      chk({in_sus, ry_n}, 2'b11);
      op(FCD_OP_PROGRAM, 18'h00010, 16'h0F0F, 0);
      em[18'h10] = rd(18'h10) & 16'h0F0F;
      chk(in_sus, 1);
      rdchk(18'h00010);
      op(FCD_OP_RESUME, 0, 0, 0);
      chk(in_sus, 0);
      wait_ry;
      op(FCD_OP_CHIP_ERASE, 0, 0, 0);
      wait_ry;
      em.delete();
      rdchk(a);
      byte_mode = 1;
      op(FCD_OP_PROGRAM, 18'h00200, 16'h00A5, 0);
      em[18'h200] = 16'h00A5;
      rdchk(18'h00200);
      byte_mode = 0;
      op(FCD_OP_PROGRAM, 18'h00300, 16'h1111, 0, 45);
      @(negedge clk);
      chk({fl_rst_n, ready}, 2'b11);
      rdchk(18'h00300);
      op(FCD_OP_PROGRAM, 18'h00300, 16'h1111, 0);
      em[18'h300] = 16'h1111;
      rdchk(18'h00300);
      close_out;
   end
endmodule
